// File: verilog/uhr_pkg.sv
package uhr_pkg;

  // ****************************************
  // Host register addresses
  // ****************************************
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_IIR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LCR_DIV_ACCESS = 7;
  localparam int MCR_LOOP = 4;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_RTS = 1;
  localparam int MCR_DTR = 0;
  localparam int IER_MODEM = 3;
  localparam int IER_LINE = 2;
  localparam int IER_TX_HOLDING_EMPTY = 1;
  localparam int IER_RXDATA = 0;
  localparam int LSR_TRANSMITTER_EMPTY = 6;
  localparam int MSR_DCD = 7;
  localparam int MSR_RI = 6;
  localparam int MSR_DSR = 5;
  localparam int MSR_CTS = 4;
  localparam logic [1:0] MCR_IRQ_GATED = 2'h2;

  // ****************************************
  // Storage and timing
  // ****************************************
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int DEPTH = 16;
  localparam logic [CNT_W-1:0] CAP_FIFO = 5'h10;
  localparam logic [CNT_W-1:0] CAP_SINGLE = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_1 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_4 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_8 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_14 = 5'h0e;

  // ****************************************
  // Identification codes and reset values
  // ****************************************
  localparam logic [2:0] IID_LINE = 3'h3;
  localparam logic [2:0] IID_RXDATA = 3'h2;
  localparam logic [2:0] IID_TIMEOUT = 3'h6;
  localparam logic [2:0] IID_TX_HOLDING_EMPTY = 3'h1;
  localparam logic [2:0] IID_MODEM = 3'h0;
  localparam logic [1:0] IIR_FIFO_ON = 2'h3;
  localparam logic [1:0] IIR_FIFO_OFF = 2'h0;
  localparam logic [3:0] RST_IER = 4'h0;
  localparam logic [7:0] RST_LCR = 8'h00;
  localparam logic [4:0] RST_MCR = 5'h00;
  localparam logic [7:0] RST_DIV = 8'h00;

  typedef enum logic [3:0] {
    MPU_SEL_NONE = 4'h0,
    MPU_SEL_RXBUF = 4'h1,
    MPU_SEL_TXHOLD = 4'h2,
    MPU_SEL_LSR = 4'h3,
    MPU_SEL_MSR = 4'h4,
    MPU_SEL_IER = 4'h5,
    MPU_SEL_LCR = 4'h6,
    MPU_SEL_MCR = 4'h7,
    MPU_SEL_DIV_LO = 4'h8,
    MPU_SEL_DIV_HI = 4'h9
  } uhr_mpu_sel_type;

  typedef struct packed {
    logic rd;
    logic wr;
    uhr_mpu_sel_type sel;
    logic [7:0] wdata;
  } uhr_mpu_req_type;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] data;
  } uhr_host_bus_type;

endpackage : uhr_pkg

// File: verilog/uhr_host_port.sv
// What this block does
// R01: Identification bits 7:6 read 11 in FIFO mode, else 00.
// R02: Identification bit 0 low while an enabled interrupt pends; bits 5:4 zero.
// R03: Identification read freezes contents and pin; new events still recorded.
// R04: Identification field reports highest pending source by fixed priority.
// R05: Each interrupt source clears by its own documented access.
// R06: Line status bit 7 shows any stored errored byte, FIFO mode only.
// R07: Transmitter-empty written by processor, automatic in double buffer mode.
// R08: Holding-empty sets when store empties, clears on host write.
// R09: Host holding-empty delayed by transmit timer; processor copy undelayed.
// R10: Processor error bits go to shadow, copied at next receive write.
// R11: Byte errors appear at head, accumulate, clear on line status read.
// R12: Receive write into full store flags overrun and drops the byte.
// R13: Data ready set on receive write, optionally delayed; shadow undelayed.
// R14: Interrupt enable bits 7:4 always read zero.
// R15: Modem enable with any bit of modem status 3:0 raises the interrupt.
// R16: Line enable with any of overrun, parity, framing, break raises it.
// R17: Holding-empty and received-data enables raise their interrupts.
// R18: Divisor access bit redirects addresses 0 and 1 to divisor bytes.
// R19: Loop mode mirrors modem control outputs into modem status 3:0.
// R20: Out2 gates interrupt pin drive when control bits 2:1 are 10.
// R21: Processor writes modem status bits 7:4 itself.
// R22: Delta bits set on changes, ring on falling edge; cleared by read.
// R23: Read side effects happen once per read strobe, after capture.
module uhr_host_port (
  input wire logic I_CLK_SYS, // 50 MHz system clock
  input wire logic I_SYS_RST, // Synchronous reset, active high
  input wire logic I_HOST_CS_N, // Host chip select
  input wire logic I_HOST_RD_N, // Host read strobe
  input wire logic I_HOST_WR_N, // Host write strobe
  input wire logic [2:0] I_HOST_ADDR, // Host register address
  input wire logic [7:0] I_HOST_DATA, // Host write data
  output logic [7:0] O_HOST_DATA, // Host read data
  output logic O_HOST_DATA_OE, // Host data drive enable
  output logic O_HOST_IRQ, // Host interrupt level
  output logic O_HOST_IRQ_OE, // Host interrupt pin drive enable
  input wire uhr_pkg::uhr_mpu_req_type I_MPU_REQ, // Processor access
  output logic [7:0] O_MPU_RDATA, // Processor read data
  input wire logic I_FIFO_MODE, // FIFO mode enabled
  input wire logic [1:0] I_RX_TRIG_SEL, // Receive trigger level code
  input wire logic I_DBL_BUF_EN, // Double buffer mode
  input wire logic I_RX_TIMER_EN, // Receive delay enable
  input wire logic [7:0] I_RX_TIME_CONST, // Receive delay in cycles
  input wire logic I_TX_TIMER_EN, // Transmit delay enable
  input wire logic [7:0] I_TX_TIME_CONST, // Transmit delay in cycles
  input wire logic I_RX_TIMEOUT // Receiver timeout pulse
);

  // ****************************************
  // Host pin synchronisers
  // ****************************************
  uhr_pkg::uhr_host_bus_type pin_now, sync1_reg, sync2_reg, sync3_reg;
  logic rd_act, wr_act, rd_act_reg, wr_act_reg;
  logic rd_start, rd_end, wr_start;
  logic [2:0] rd_addr_reg;

  assign pin_now = '{cs: ~I_HOST_CS_N, rd: ~I_HOST_RD_N, wr: ~I_HOST_WR_N,
                     addr: I_HOST_ADDR, data: I_HOST_DATA};

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pin_now;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Strobe counts only once stages two and three agree
  assign rd_act = (sync2_reg.cs & sync2_reg.rd) & (sync3_reg.cs & sync3_reg.rd) ? 1'b1 :
                  ((sync2_reg.cs & sync2_reg.rd) | (sync3_reg.cs & sync3_reg.rd)) & rd_act_reg;
  assign wr_act = (sync2_reg.cs & sync2_reg.wr) & (sync3_reg.cs & sync3_reg.wr) ? 1'b1 :
                  ((sync2_reg.cs & sync2_reg.wr) | (sync3_reg.cs & sync3_reg.wr)) & wr_act_reg;
  assign rd_start = rd_act & ~rd_act_reg;
  assign rd_end = ~rd_act & rd_act_reg;
  assign wr_start = wr_act & ~wr_act_reg;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      rd_addr_reg <= 3'h0;
    end else begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
      if (rd_start) begin
        rd_addr_reg <= sync3_reg.addr;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [3:0] ier_reg;
  logic [7:0] lcr_reg, div_lo_reg, div_hi_reg;
  logic [4:0] mcr_reg;
  logic dlab;
  logic host_rd_fire, host_wr_data, host_rd_data, host_rd_iir, host_rd_lsr, host_rd_msr;

  assign dlab = lcr_reg[uhr_pkg::LCR_DIV_ACCESS];
  // Effects fire at the end of the strobe, after the value was captured
  assign host_rd_fire = rd_end; // [R23]
  assign host_rd_data = host_rd_fire & (rd_addr_reg == uhr_pkg::ADDR_DATA) & ~dlab; // [R18]
  assign host_rd_iir = host_rd_fire & (rd_addr_reg == uhr_pkg::ADDR_IIR);
  assign host_rd_lsr = host_rd_fire & (rd_addr_reg == uhr_pkg::ADDR_LSR);
  assign host_rd_msr = host_rd_fire & (rd_addr_reg == uhr_pkg::ADDR_MSR);
  assign host_wr_data = wr_start & (sync3_reg.addr == uhr_pkg::ADDR_DATA) & ~dlab; // [R18]

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      ier_reg <= uhr_pkg::RST_IER;
      lcr_reg <= uhr_pkg::RST_LCR;
      mcr_reg <= uhr_pkg::RST_MCR;
      div_lo_reg <= uhr_pkg::RST_DIV;
      div_hi_reg <= uhr_pkg::RST_DIV;
    end else if (wr_start) begin
      unique case (sync3_reg.addr)
        uhr_pkg::ADDR_DATA: if (dlab) div_lo_reg <= sync3_reg.data; // [R18]
        uhr_pkg::ADDR_IER: begin
          if (dlab) begin
            div_hi_reg <= sync3_reg.data; // [R18]
          end else begin
            ier_reg <= sync3_reg.data[3:0];
          end
        end
        uhr_pkg::ADDR_LCR: lcr_reg <= sync3_reg.data;
        uhr_pkg::ADDR_MCR: mcr_reg <= sync3_reg.data[4:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Receive store
  // ****************************************
  localparam int DEPTH_RX = uhr_pkg::DEPTH;
  logic [7:0] rx_data_mem [DEPTH_RX];
  logic [2:0] rx_err_mem [DEPTH_RX];
  logic [uhr_pkg::PTR_W-1:0] rx_wr_ptr_reg, rx_rd_ptr_reg;
  logic [uhr_pkg::CNT_W-1:0] rx_cnt_reg, rx_cnt_next, cap, trig, tx_cnt_reg, tx_cnt_next;
  logic mpu_wr, mpu_rd, rx_push_req, rx_push, rx_pop, fifo_mode_reg, flush;

  assign mpu_wr = I_MPU_REQ.wr;
  assign mpu_rd = I_MPU_REQ.rd;
  assign cap = I_FIFO_MODE ? uhr_pkg::CAP_FIFO : uhr_pkg::CAP_SINGLE;
  // Changing mode throws away both stores
  assign flush = fifo_mode_reg != I_FIFO_MODE;
  assign rx_push_req = mpu_wr & (I_MPU_REQ.sel == uhr_pkg::MPU_SEL_RXBUF);
  assign rx_push = rx_push_req & (rx_cnt_reg < cap); // [R12]
  assign rx_pop = host_rd_data & (rx_cnt_reg != '0);

  always_comb begin
    rx_cnt_next = rx_cnt_reg;
    if (flush) begin
      rx_cnt_next = '0;
    end else if (rx_push & ~rx_pop) begin
      rx_cnt_next = rx_cnt_reg + 5'h01;
    end else if (rx_pop & ~rx_push) begin
      rx_cnt_next = rx_cnt_reg - 5'h01;
    end
  end

  always_comb begin
    unique case (I_RX_TRIG_SEL)
      2'h0: trig = uhr_pkg::TRIG_1;
      2'h1: trig = uhr_pkg::TRIG_4;
      2'h2: trig = uhr_pkg::TRIG_8;
      2'h3: trig = uhr_pkg::TRIG_14;
    endcase
  end

  logic [2:0] err_shadow_reg;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      rx_wr_ptr_reg <= '0;
      rx_rd_ptr_reg <= '0;
      rx_cnt_reg <= '0;
      fifo_mode_reg <= 1'b0;
    end else begin
      fifo_mode_reg <= I_FIFO_MODE;
      rx_cnt_reg <= rx_cnt_next;
      if (flush) begin
        rx_wr_ptr_reg <= '0;
        rx_rd_ptr_reg <= '0;
      end else begin
        if (rx_push) begin
          rx_wr_ptr_reg <= rx_wr_ptr_reg + 4'h1;
        end
        if (rx_pop) begin
          rx_rd_ptr_reg <= rx_rd_ptr_reg + 4'h1;
        end
      end
    end
  end

  // Data storage needs no reset; occupancy is tracked by the count
  always_ff @(posedge I_CLK_SYS) begin
    if (rx_push) begin
      rx_data_mem[rx_wr_ptr_reg] <= I_MPU_REQ.wdata;
      rx_err_mem[rx_wr_ptr_reg] <= err_shadow_reg; // [R10]
    end
  end

  // Shadow errors are consumed by every receive write, stored or not
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      err_shadow_reg <= 3'h0;
    end else if (rx_push_req) begin
      err_shadow_reg <= 3'h0; // [R10]
    end else if (mpu_wr & (I_MPU_REQ.sel == uhr_pkg::MPU_SEL_LSR)) begin
      err_shadow_reg <= I_MPU_REQ.wdata[4:2]; // [R10]
    end
  end

  logic fifo_err_any;

  always_comb begin
    fifo_err_any = 1'b0;
    for (int i = 0; i < DEPTH_RX; i++) begin
      if (5'(i) < rx_cnt_reg) begin
        fifo_err_any = fifo_err_any | (|rx_err_mem[4'(rx_rd_ptr_reg + 4'(i))]);
      end
    end
  end

  // ****************************************
  // Line status
  // ****************************************
  logic head_new, head_new_reg, overrun_reg, transmitter_empty_reg, timeout_reg;
  logic [2:0] lsr_err_reg;
  logic [7:0] rx_delay_reg;
  logic dr_host_reg, lsr_bit7;

  // A byte becomes head when it lands in an empty store or its predecessor leaves
  assign head_new = ~flush & (rx_pop ? (rx_cnt_next != '0) : (rx_push & (rx_cnt_reg == '0)));
  assign lsr_bit7 = I_FIFO_MODE & fifo_err_any; // [R06]

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      head_new_reg <= 1'b0;
      lsr_err_reg <= 3'h0;
      overrun_reg <= 1'b0;
    end else begin
      head_new_reg <= head_new;
      if (head_new_reg) begin
        lsr_err_reg <= lsr_err_reg | rx_err_mem[rx_rd_ptr_reg]; // [R11]
      end else if (host_rd_lsr) begin
        lsr_err_reg <= 3'h0; // [R11]
      end
      if (rx_push_req & ~rx_push) begin
        overrun_reg <= 1'b1; // [R12]
      end else if (host_rd_lsr) begin
        overrun_reg <= 1'b0; // [R12]
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      transmitter_empty_reg <= 1'b1;
    end else if (I_DBL_BUF_EN) begin
      transmitter_empty_reg <= tx_cnt_reg == '0; // [R07]
    end else if (mpu_wr & (I_MPU_REQ.sel == uhr_pkg::MPU_SEL_LSR)) begin
      transmitter_empty_reg <= I_MPU_REQ.wdata[uhr_pkg::LSR_TRANSMITTER_EMPTY]; // [R07]
    end
  end

  // Host data ready trails the processor's shadow by the receive delay
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      dr_host_reg <= 1'b0;
      rx_delay_reg <= 8'h00;
    end else if (rx_cnt_next == '0) begin
      dr_host_reg <= 1'b0; // [R13]
      rx_delay_reg <= 8'h00;
    end else if (rx_push & I_RX_TIMER_EN & (I_RX_TIME_CONST != 8'h00)) begin
      rx_delay_reg <= I_RX_TIME_CONST; // [R13]
    end else if (rx_push) begin
      dr_host_reg <= 1'b1; // [R13]
    end else if (rx_delay_reg != 8'h00) begin
      rx_delay_reg <= rx_delay_reg - 8'h01;
      if (rx_delay_reg == 8'h01) begin
        dr_host_reg <= 1'b1; // [R13]
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      timeout_reg <= 1'b0;
    end else if (I_RX_TIMEOUT & (rx_cnt_reg != '0) & ~flush) begin
      timeout_reg <= 1'b1;
    end else if (host_rd_data | flush) begin
      timeout_reg <= 1'b0; // [R05]
    end
  end

  // ****************************************
  // Transmit store
  // ****************************************
  logic [7:0] tx_mem [DEPTH_RX];
  logic [uhr_pkg::PTR_W-1:0] tx_wr_ptr_reg, tx_rd_ptr_reg;
  logic tx_push, tx_pop, tx_holding_empty_host_reg, tx_holding_empty_host_d_reg;
  logic [7:0] tx_delay_reg;

  assign tx_push = host_wr_data & (tx_cnt_reg < cap);
  assign tx_pop = mpu_rd & (I_MPU_REQ.sel == uhr_pkg::MPU_SEL_TXHOLD) & (tx_cnt_reg != '0);

  always_comb begin
    tx_cnt_next = tx_cnt_reg;
    if (flush) begin
      tx_cnt_next = '0;
    end else if (tx_push & ~tx_pop) begin
      tx_cnt_next = tx_cnt_reg + 5'h01;
    end else if (tx_pop & ~tx_push) begin
      tx_cnt_next = tx_cnt_reg - 5'h01;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      tx_wr_ptr_reg <= '0;
      tx_rd_ptr_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      tx_cnt_reg <= tx_cnt_next;
      if (flush) begin
        tx_wr_ptr_reg <= '0;
        tx_rd_ptr_reg <= '0;
      end else begin
        if (tx_push) tx_wr_ptr_reg <= tx_wr_ptr_reg + 4'h1;
        if (tx_pop) tx_rd_ptr_reg <= tx_rd_ptr_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (tx_push) begin
      tx_mem[tx_wr_ptr_reg] <= sync3_reg.data;
    end
  end

  // Shadow copy is the plain empty state; the host copy waits for the delay
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      tx_holding_empty_host_reg <= 1'b1;
      tx_delay_reg <= 8'h00;
    end else if (tx_cnt_next != '0) begin
      tx_holding_empty_host_reg <= 1'b0; // [R08]
      tx_delay_reg <= 8'h00;
    end else if (tx_pop & I_TX_TIMER_EN & (I_TX_TIME_CONST != 8'h00)) begin
      tx_delay_reg <= I_TX_TIME_CONST; // [R09]
    end else if (tx_pop | flush) begin
      tx_holding_empty_host_reg <= 1'b1; // [R08]
    end else if (tx_delay_reg != 8'h00) begin
      tx_delay_reg <= tx_delay_reg - 8'h01;
      if (tx_delay_reg == 8'h01) begin
        tx_holding_empty_host_reg <= 1'b1; // [R09]
      end
    end
  end

  // ****************************************
  // Modem status
  // ****************************************
  logic [3:0] msr_hi_reg, delta_reg, delta_set, msr_lo;
  logic [7:0] msr_wr;

  assign msr_wr = I_MPU_REQ.wdata;

  always_comb begin
    delta_set = 4'h0;
    if (mpu_wr & (I_MPU_REQ.sel == uhr_pkg::MPU_SEL_MSR)) begin
      delta_set[3] = msr_wr[uhr_pkg::MSR_DCD] ^ msr_hi_reg[3]; // [R22]
      delta_set[2] = ~msr_wr[uhr_pkg::MSR_RI] & msr_hi_reg[2]; // [R22]
      delta_set[1] = msr_wr[uhr_pkg::MSR_DSR] ^ msr_hi_reg[1]; // [R22]
      delta_set[0] = msr_wr[uhr_pkg::MSR_CTS] ^ msr_hi_reg[0]; // [R22]
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      msr_hi_reg <= 4'h0;
      delta_reg <= 4'h0;
    end else begin
      if (mpu_wr & (I_MPU_REQ.sel == uhr_pkg::MPU_SEL_MSR)) begin
        msr_hi_reg <= msr_wr[7:4]; // [R21]
      end
      // A change landing on the clearing read still counts
      delta_reg <= (host_rd_msr ? 4'h0 : delta_reg) | delta_set; // [R22]
    end
  end

  assign msr_lo = mcr_reg[uhr_pkg::MCR_LOOP] ?
                  {mcr_reg[uhr_pkg::MCR_OUT1], mcr_reg[uhr_pkg::MCR_OUT2],
                   mcr_reg[uhr_pkg::MCR_DTR], mcr_reg[uhr_pkg::MCR_RTS]} : delta_reg; // [R19]

  // ****************************************
  // Interrupt priority
  // ****************************************
  logic tx_holding_empty_int_reg, p_line, p_rx, p_to, p_tx_holding_empty, p_modem, any_pend;
  logic [2:0] iid;
  logic [7:0] iir_val, lsr_val, host_rd_val;
  logic iir_frozen;

  assign iir_frozen = rd_act_reg & (rd_addr_reg == uhr_pkg::ADDR_IIR); // [R03]
  assign p_line = ier_reg[uhr_pkg::IER_LINE] & (overrun_reg | (|lsr_err_reg)); // [R16]
  assign p_rx = ier_reg[uhr_pkg::IER_RXDATA] & dr_host_reg &
                (~I_FIFO_MODE | (rx_cnt_reg >= trig)); // [R17]
  assign p_to = ier_reg[uhr_pkg::IER_RXDATA] & timeout_reg; // [R17]
  assign p_tx_holding_empty = ier_reg[uhr_pkg::IER_TX_HOLDING_EMPTY] & tx_holding_empty_int_reg; // [R17]
  assign p_modem = ier_reg[uhr_pkg::IER_MODEM] & (|msr_lo); // [R15]
  assign any_pend = p_line | p_rx | p_to | p_tx_holding_empty | p_modem;

  always_comb begin
    if (p_line) iid = uhr_pkg::IID_LINE; // [R04]
    else if (p_rx) iid = uhr_pkg::IID_RXDATA;
    else if (p_to) iid = uhr_pkg::IID_TIMEOUT;
    else if (p_tx_holding_empty) iid = uhr_pkg::IID_TX_HOLDING_EMPTY;
    else iid = uhr_pkg::IID_MODEM;
  end

  assign iir_val = {I_FIFO_MODE ? uhr_pkg::IIR_FIFO_ON : uhr_pkg::IIR_FIFO_OFF, // [R01]
                    2'h0, iid, ~any_pend}; // [R02]

  // Latches the rise of enabled holding-empty, so enabling while empty fires too
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      tx_holding_empty_host_d_reg <= 1'b0;
      tx_holding_empty_int_reg <= 1'b0;
    end else begin
      tx_holding_empty_host_d_reg <= tx_holding_empty_host_reg & ier_reg[uhr_pkg::IER_TX_HOLDING_EMPTY];
      if (tx_holding_empty_host_reg & ier_reg[uhr_pkg::IER_TX_HOLDING_EMPTY] & ~tx_holding_empty_host_d_reg) begin // [R17]
        tx_holding_empty_int_reg <= 1'b1;
      end else if (host_wr_data | (host_rd_iir & (O_HOST_DATA[3:1] == uhr_pkg::IID_TX_HOLDING_EMPTY))) begin
        tx_holding_empty_int_reg <= 1'b0; // [R05]
      end
    end
  end

  // ****************************************
  // Host read path and pins
  // ****************************************
  assign lsr_val = {lsr_bit7, transmitter_empty_reg, tx_holding_empty_host_reg, lsr_err_reg, overrun_reg, dr_host_reg};

  always_comb begin
    unique case (sync3_reg.addr)
      uhr_pkg::ADDR_DATA: host_rd_val = dlab ? div_lo_reg : rx_data_mem[rx_rd_ptr_reg];
      uhr_pkg::ADDR_IER: host_rd_val = dlab ? div_hi_reg : {4'h0, ier_reg}; // [R14]
      uhr_pkg::ADDR_IIR: host_rd_val = iir_val;
      uhr_pkg::ADDR_LCR: host_rd_val = lcr_reg;
      uhr_pkg::ADDR_MCR: host_rd_val = {3'h0, mcr_reg};
      uhr_pkg::ADDR_LSR: host_rd_val = lsr_val;
      uhr_pkg::ADDR_MSR: host_rd_val = {msr_hi_reg, msr_lo};
      default: host_rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_HOST_DATA <= 8'h00;
      O_HOST_DATA_OE <= 1'b0;
      O_HOST_IRQ <= 1'b0;
      O_HOST_IRQ_OE <= 1'b1;
    end else begin
      if (rd_start) begin
        O_HOST_DATA <= host_rd_val; // [R23]
      end
      O_HOST_DATA_OE <= rd_act;
      if (~iir_frozen) begin
        O_HOST_IRQ <= any_pend; // [R03]
      end
      O_HOST_IRQ_OE <= (mcr_reg[2:1] == uhr_pkg::MCR_IRQ_GATED) ?
                       mcr_reg[uhr_pkg::MCR_OUT2] : 1'b1; // [R20]
    end
  end

  // ****************************************
  // Processor read path
  // ****************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_MPU_RDATA <= 8'h00;
    end else if (mpu_rd) begin
      unique case (I_MPU_REQ.sel)
        uhr_pkg::MPU_SEL_TXHOLD: O_MPU_RDATA <= tx_mem[tx_rd_ptr_reg];
        uhr_pkg::MPU_SEL_LSR: O_MPU_RDATA <= {lsr_bit7, transmitter_empty_reg, tx_cnt_reg == '0,
                                              lsr_err_reg, overrun_reg,
                                              rx_cnt_reg != '0}; // [R09] [R13]
        uhr_pkg::MPU_SEL_MSR: O_MPU_RDATA <= {msr_hi_reg, msr_lo};
        uhr_pkg::MPU_SEL_IER: O_MPU_RDATA <= {4'h0, ier_reg}; // [R14]
        uhr_pkg::MPU_SEL_LCR: O_MPU_RDATA <= lcr_reg;
        uhr_pkg::MPU_SEL_MCR: O_MPU_RDATA <= {3'h0, mcr_reg};
        uhr_pkg::MPU_SEL_DIV_LO: O_MPU_RDATA <= div_lo_reg;
        uhr_pkg::MPU_SEL_DIV_HI: O_MPU_RDATA <= div_hi_reg;
        default: O_MPU_RDATA <= 8'h00;
      endcase
    end
  end

endmodule : uhr_host_port

// File: bench/uhr_mpu_model.sv
module uhr_mpu_model (
  input wire logic clk, rd, wr, // Clock, one-cycle command pulses
  input wire uhr_pkg::uhr_mpu_sel_type sel, // Register selected
  input wire logic [7:0] wdata, // Write data
  output uhr_pkg::uhr_mpu_req_type req // Request to the port
);
  timeunit 1ns;
  timeprecision 1ps;
  // Launched from the edge so the port never sees a mid-cycle change
  initial req = '0;
  always @(posedge clk) req <= '{rd, wr, sel, wdata};
endmodule : uhr_mpu_model

// File: bench/uhr_host_port_monitor.sv
module uhr_host_port_monitor (
  input wire logic I_CLK_SYS, I_SYS_RST, I_HOST_CS_N, I_HOST_RD_N, I_HOST_WR_N, I_FIFO_MODE,
  input wire logic O_HOST_DATA_OE, O_HOST_IRQ, O_HOST_IRQ_OE, I_DBL_BUF_EN, I_RX_TIMEOUT,
  input wire logic I_RX_TIMER_EN, I_TX_TIMER_EN,
  input wire logic [1:0] I_RX_TRIG_SEL,
  input wire logic [2:0] I_HOST_ADDR,
  input wire logic [7:0] I_HOST_DATA, O_HOST_DATA, O_MPU_RDATA, I_RX_TIME_CONST, I_TX_TIME_CONST,
  input wire uhr_pkg::uhr_mpu_req_type I_MPU_REQ
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  // ****************
  // Port checks
  // ****************
  data_hold_a: assert property (!$past(I_SYS_RST) && !$rose(O_HOST_DATA_OE)
    |-> $stable(O_HOST_DATA)) else $error("host data moved");
  oe_cause_a: assert property ($rose(O_HOST_DATA_OE)
    |-> $past(!I_HOST_RD_N && !I_HOST_CS_N, 2)) else $error("drive without read");
  oe_stand_a: assert property (O_HOST_DATA_OE && !I_HOST_RD_N |=> O_HOST_DATA_OE)
    else $error("drive dropped early");
  oe_end_a: assert property (I_HOST_RD_N [*6] |-> !O_HOST_DATA_OE)
    else $error("drive held late");
  mpu_hold_a: assert property (!$past(I_SYS_RST) && !$past(I_MPU_REQ.rd)
    |-> $stable(O_MPU_RDATA)) else $error("mpu data moved");
  mpu_ier_a: assert property (I_MPU_REQ.rd && I_MPU_REQ.sel == uhr_pkg::MPU_SEL_IER
    |=> O_MPU_RDATA[7:4] == 4'h0) else $error("enable top bits set");
  iir_fixed_a: assert property ($rose(O_HOST_DATA_OE) && I_HOST_ADDR == 3'h2
    |-> O_HOST_DATA[7:4] == {I_FIFO_MODE, I_FIFO_MODE, 2'h0}) else $error("ident top bad");
  lsr_top_a: assert property ($rose(O_HOST_DATA_OE) && I_HOST_ADDR == 3'h5 && !I_FIFO_MODE
    |-> !O_HOST_DATA[7]) else $error("status bit 7 set");
  cover property ($rose(O_HOST_DATA_OE) && I_HOST_ADDR == 3'h2);
  cover property (O_HOST_IRQ ##1 !O_HOST_IRQ);
  cover property (!O_HOST_IRQ_OE);
endmodule : uhr_host_port_monitor
bind uhr_host_port uhr_host_port_monitor u_mon (.*);

// File: bench/uhr_host_port_bench.sv
module uhr_host_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CLK_SYS = 0, I_SYS_RST = 1, I_HOST_CS_N = 1, I_HOST_RD_N = 1, I_HOST_WR_N = 1;
  logic I_FIFO_MODE = 0, I_DBL_BUF_EN = 0, I_RX_TIMER_EN = 0, I_TX_TIMER_EN = 0;
  logic I_RX_TIMEOUT = 0, O_HOST_DATA_OE, O_HOST_IRQ, O_HOST_IRQ_OE, m_rd = 0, m_wr = 0;
  logic [1:0] I_RX_TRIG_SEL = 0;
  logic [2:0] I_HOST_ADDR = 0;
  logic [7:0] I_HOST_DATA = 0, I_RX_TIME_CONST = 0, I_TX_TIME_CONST = 0;
  logic [7:0] O_HOST_DATA, O_MPU_RDATA, m_d = 0, q;
  uhr_pkg::uhr_mpu_sel_type m_sel = uhr_pkg::MPU_SEL_NONE;
  uhr_pkg::uhr_mpu_req_type I_MPU_REQ;
  int n_fail = 0, n_checks = 0, cyc = 0;
  uhr_host_port u_dut (.*);
  uhr_mpu_model u_mpu (.clk(I_CLK_SYS), .rd(m_rd), .wr(m_wr), .sel(m_sel), .wdata(m_d),
    .req(I_MPU_REQ));
  // ****************
  // Bus tasks
  // ****************
  initial forever #10 I_CLK_SYS = ~I_CLK_SYS;
  // Run needs about 400 cycles
  always @(posedge I_CLK_SYS) if (++cyc > 5000) begin
    n_fail++;
    end_of_test();
  end
  task automatic end_of_test();
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK_SYS);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Strobe held past the synchroniser so read data has settled
  task automatic hrd(input logic [2:0] a);
    {I_HOST_ADDR, I_HOST_CS_N, I_HOST_RD_N} = {a, 2'h0};
    for (int i = 0; i < 20 && O_HOST_DATA_OE !== 1'b1; i++) tick(1);
    tick(3);
    q = O_HOST_DATA;
    {I_HOST_CS_N, I_HOST_RD_N} = 2'h3;
    tick(8);
  endtask : hrd
  task automatic rc(input string nm, input logic [2:0] a, input logic [7:0] e);
    hrd(a);
    chk(nm, q, e);
  endtask : rc
  task automatic hwr(input logic [2:0] a, input logic [7:0] v);
    {I_HOST_ADDR, I_HOST_DATA, I_HOST_CS_N, I_HOST_WR_N} = {a, v, 2'h0};
    tick(6);
    {I_HOST_CS_N, I_HOST_WR_N} = 2'h3;
    tick(6);
  endtask : hwr
  task automatic mpu(input logic w, input uhr_pkg::uhr_mpu_sel_type s, input logic [7:0] v);
    m_sel = s;
    {m_wr, m_rd, m_d} = {w, !w, v};
    tick(1);
    {m_wr, m_rd} = 2'h0;
    tick(3);
  endtask : mpu
  task automatic t_irq();
    hwr(3'h1, 8'hff);
    chk("irq", {7'h0, O_HOST_IRQ}, 8'h01);
    mpu(1'b0, uhr_pkg::MPU_SEL_IER, 8'h00);
    chk("mpu_ier", O_MPU_RDATA, 8'h0f);
    rc("iir", 3'h2, 8'h02);
    rc("iir", 3'h2, 8'h01);
    chk("irq", {7'h0, O_HOST_IRQ}, 8'h00);
  endtask : t_irq
  task automatic t_line();
    mpu(1'b1, uhr_pkg::MPU_SEL_LSR, 8'h04);
    mpu(1'b1, uhr_pkg::MPU_SEL_RXBUF, 8'h5a);
    mpu(1'b1, uhr_pkg::MPU_SEL_RXBUF, 8'ha5);
    rc("iir", 3'h2, 8'h06);
    rc("lsr", 3'h5, 8'h27);
    rc("iir", 3'h2, 8'h04);
    rc("rx", 3'h0, 8'h5a);
    rc("lsr", 3'h5, 8'h20);
  endtask : t_line
  task automatic t_msr();
    mpu(1'b1, uhr_pkg::MPU_SEL_MSR, 8'hb0);
    rc("iir", 3'h2, 8'h00);
    rc("msr", 3'h6, 8'hbb);
    mpu(1'b1, uhr_pkg::MPU_SEL_MSR, 8'hf0);
    mpu(1'b1, uhr_pkg::MPU_SEL_MSR, 8'hb0);
    rc("msr", 3'h6, 8'hb4);
  endtask : t_msr
  task automatic t_loop();
    hwr(3'h4, 8'h15);
    rc("msr", 3'h6, 8'hba);
    chk("irq_oe", {7'h0, O_HOST_IRQ_OE}, 8'h00);
    hwr(3'h4, 8'h0c);
    chk("irq_oe", {7'h0, O_HOST_IRQ_OE}, 8'h01);
  endtask : t_loop
  task automatic t_div();
    hwr(3'h3, 8'h80);
    hwr(3'h1, 8'h12);
    rc("div_hi", 3'h1, 8'h12);
    hwr(3'h3, 8'h00);
    rc("ier", 3'h1, 8'h0f);
  endtask : t_div
  task automatic t_fifo();
    I_FIFO_MODE = 1'b1;
    tick(4);
    hrd(3'h2);
    chk("iir_top", q & 8'hf0, 8'hc0);
    mpu(1'b1, uhr_pkg::MPU_SEL_LSR, 8'h48);
    mpu(1'b1, uhr_pkg::MPU_SEL_RXBUF, 8'h11);
    hrd(3'h5);
    chk("lsr_err", q & 8'h89, 8'h89);
  endtask : t_fifo
  task automatic t_tx();
    rc("rx", 3'h0, 8'h11);
    hwr(3'h0, 8'h3c);
    rc("lsr", 3'h5, 8'h40);
    mpu(1'b0, uhr_pkg::MPU_SEL_TXHOLD, 8'h00);
    chk("tx", O_MPU_RDATA, 8'h3c);
    rc("iir", 3'h2, 8'hc2);
    rc("iir", 3'h2, 8'hc1);
  endtask : t_tx
  initial begin
    repeat (5) @(posedge I_CLK_SYS);
    #1 I_SYS_RST = 0;
    chk("irq_oe", {7'h0, O_HOST_IRQ_OE}, 8'h01);
    t_irq();
    t_line();
    t_msr();
    t_loop();
    t_div();
    t_fifo();
    t_tx();
    end_of_test();
  end
endmodule : uhr_host_port_bench
